// ===== hw/fpl_pkg.sv
package fpl_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ       = 25_000_000;  // pclk rate
  localparam int unsigned TICK_US      = 1000;        // Lamp timebase period in us
  localparam int unsigned TICK_CYCLES  = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned LAMP_MIN_MS  = 50;          // Least visible lamp-on time
  localparam int unsigned LAMP_MIN_TICKS = (LAMP_MIN_MS * 1000 + TICK_US - 1) / TICK_US;

  // Register map, byte addresses
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  OFF_STAGE    = 8'h00;       // Progress stage, rw
  localparam logic [7:0]  OFF_STATUS   = 8'h04;       // Sticky events, w1c
  localparam logic [7:0]  OFF_MASK     = 8'h08;       // Interrupt mask, rw
  localparam logic [7:0]  OFF_LAMPS    = 8'h0C;       // Lamp state, ro

  // Reset values
  localparam logic [3:0]  MASK_RST     = 4'h0;
  localparam logic [3:0]  STATUS_RST   = 4'h0;

  // Status and mask bit positions
  localparam int unsigned EV_SYSFAIL   = 0;           // Backplane failure line rose
  localparam int unsigned EV_ACCESS    = 1;           // Remote master access began
  localparam int unsigned EV_BADSTEP   = 2;           // Refused stage write
  localparam int unsigned EV_STAGE     = 3;           // Stage accepted
  localparam int unsigned EV_N         = 4;

  // Synchronised pin inputs, index into the sync vector
  localparam int unsigned PIN_SYSFAIL  = 0;
  localparam int unsigned PIN_MODID    = 1;
  localparam int unsigned PIN_REMOTE   = 2;
  localparam int unsigned PIN_DISK     = 3;
  localparam int unsigned PIN_SPEED    = 4;
  localparam int unsigned PIN_N        = 5;

  // Startup progress states
  typedef enum logic [2:0] {
    FPL_OFF       = 3'b000,  // Unpowered
    FPL_BOOT      = 3'b001,  // Operating system boot
    FPL_SELFTEST  = 3'b010,  // Self-test and board_init_routine
    FPL_PASSED    = 3'b011,  // Self-test passed
    FPL_MGR_INIT  = 3'b100,  // resource_manager startup
    FPL_ONLINE    = 3'b101,  // Online
    FPL_FAIL_MGR  = 3'b110,  // resource_manager startup failed
    FPL_FAIL_ONL  = 3'b111   // Failed while online
  } fpl_stage_t;

  // The seven front-panel lamps
  typedef struct packed {
    logic full_speed_lamp;   // Green, processor at top clock
    logic drive;             // Yellow, hard disk busy
    logic access;            // Yellow, module id or remote access
    logic sysfail;           // Red, backplane failure line
    logic online;            // Green
    logic test;              // Green
    logic failed;            // Red, this board drives failure line
  } fpl_lamps_t;

endpackage

// ===== hw/fpl_stretch.sv
`timescale 1ns/1ps
module fpl_stretch
  import fpl_pkg::*;
#(
  parameter int unsigned MIN_TICKS = LAMP_MIN_TICKS
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic tick,
  input  wire logic trig,
  output logic      lamp
);

  // Elaboration check: the hold counter is 16 bits wide
  if (MIN_TICKS < 1 || MIN_TICKS > 65535) begin : g_bad_ticks
    $error("fpl_stretch: MIN_TICKS out of range");
  end

  logic [15:0] remain;  // Ticks left of the hold

  // Reload while the trigger stands, count down on ticks after.
  // The hold starts only after the trigger falls, so one-cycle access pulses
  // still give at least MIN_TICKS-1 full ticks of light.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remain <= 16'h0000;
    end else if (trig) begin
      remain <= 16'(MIN_TICKS);
    end else if (tick && remain != 16'h0000) begin
      remain <= remain - 16'h0001;
    end
  end

  // Lamp register: lit during trigger and during the hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp <= 1'b0;
    end else begin
      lamp <= trig || (remain != 16'h0000);
    end
  end

endmodule

// ===== hw/fpl_top.sv
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module fpl_top
  import fpl_pkg::*;
#(
  parameter int unsigned TICK_DIV  = TICK_CYCLES,    // pclk cycles per lamp tick
  parameter int unsigned MIN_TICKS = LAMP_MIN_TICKS  // Least lamp-on time in ticks
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Backplane failure line, open drain, active low on the wire
  input  wire logic              sysfail_n_in,
  output logic                   sysfail_n_out,
  output logic                   sysfail_n_oe,
  // Status pins from the rest of the board
  input  wire logic              modid_in,
  input  wire logic              remote_access,
  input  wire logic              disk_busy,
  input  wire logic              cpu_full_speed,
  // Lamps and interrupt
  output fpl_lamps_t             lamps,
  output logic                   irq
);

  // Elaboration checks: the divider needs two states, the hold a 16-bit count
  if (TICK_DIV < 2) begin : g_bad_div
    $error("fpl_top: TICK_DIV must be at least 2");
  end
  if (MIN_TICKS < 1 || MIN_TICKS > 65535) begin : g_bad_hold
    $error("fpl_top: MIN_TICKS out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  //////////////////////////////////////////////////////////////////////////////

  logic [PIN_N-1:0] pin_raw;   // Pins as they arrive
  logic [PIN_N-1:0] pin_meta;  // First stage, read only by second stage
  logic [PIN_N-1:0] pin_sync;  // Safe copies for the logic

  // Failure wire inverted here so every synced pin is active high
  assign pin_raw = {cpu_full_speed, disk_busy, remote_access, modid_in, ~sysfail_n_in};

  // Two flops per pin; all pins are asynchronous to pclk
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  logic [PIN_N-1:0] pin_prev;  // Last cycle's synced pins, for edges

  // Edge history of the synchronised pins
  // Reset value equals each pin's idle level, so no false edge follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev <= '0;
    end else begin
      pin_prev <= pin_sync;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Lamp timebase
  //////////////////////////////////////////////////////////////////////////////

  logic [31:0] div_cnt;  // Divider count
  logic        tick;     // One-cycle enable each lamp tick

  // Free-running divider; a single enable avoids a second clock
  // Tick phase is never aligned to events; lamps only need to be visible
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 32'h0000_0000;
      tick    <= 1'b0;
    end else if (div_cnt == 32'(TICK_DIV - 1)) begin
      div_cnt <= 32'h0000_0000;
      tick    <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 32'h0000_0001;
      tick    <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB decode
  //////////////////////////////////////////////////////////////////////////////

  logic setup_ph;   // First cycle of a transfer
  logic access_ph;  // Completing cycle; zero wait states
  logic hit;        // Address maps to a register
  logic wr_stage;   // Write strobes per register
  logic wr_status;
  logic wr_mask;

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign hit       = (paddr == OFF_STAGE) || (paddr == OFF_STATUS) ||
                     (paddr == OFF_MASK)  || (paddr == OFF_LAMPS);
  assign wr_stage  = access_ph && pwrite && (paddr == OFF_STAGE);
  assign wr_status = access_ph && pwrite && (paddr == OFF_STATUS);
  assign wr_mask   = access_ph && pwrite && (paddr == OFF_MASK);

  // Always ready; unmapped addresses answer with an error
  // A write to the read-only lamp register is dropped without an error
  assign pready  = 1'b1;
  assign pslverr = access_ph && !hit;

  //////////////////////////////////////////////////////////////////////////////
  // Startup progress state
  //////////////////////////////////////////////////////////////////////////////

  fpl_stage_t stage;       // Current progress state
  fpl_stage_t req_stage;   // Stage named by the write data
  logic       step_ok;     // Requested stage is a legal successor

  assign req_stage = fpl_stage_t'(pwdata[2:0]);

  // Only the next state in order, or a failure from the matching state.
  // A skipped or backward write is refused so the lamps never skip a code.
  always_comb begin
    step_ok = 1'b0;
    unique case (stage)
      FPL_OFF:      step_ok = (req_stage == FPL_BOOT);
      FPL_BOOT:     step_ok = (req_stage == FPL_SELFTEST);
      FPL_SELFTEST: step_ok = (req_stage == FPL_PASSED);
      FPL_PASSED:   step_ok = (req_stage == FPL_MGR_INIT);
      FPL_MGR_INIT: step_ok = (req_stage == FPL_ONLINE) ||
                              (req_stage == FPL_FAIL_MGR);
      FPL_ONLINE:   step_ok = (req_stage == FPL_FAIL_ONL);
      FPL_FAIL_MGR: step_ok = 1'b0;
      FPL_FAIL_ONL: step_ok = 1'b0;
    endcase
  end

  // Stage register, moved only by accepted writes
  // Failure states are final; only reset takes the lamps back to dark
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage <= FPL_OFF;
    end else if (wr_stage && step_ok) begin
      stage <= req_stage;
    end
  end

  logic next_drive;  // Board should pull the failure line
  logic next_test;   // Test lamp
  logic next_onl;    // Online lamp

  // Lamp code per state; failed lamp doubles as the line drive
  // Decoded once so the lamps and the line drive share one source
  always_comb begin
    next_drive = 1'b0;
    next_test  = 1'b0;
    next_onl   = 1'b0;
    unique case (stage)
      FPL_OFF:      begin end
      FPL_BOOT:     next_drive = 1'b1;
      FPL_SELFTEST: begin
        next_drive = 1'b1;
        next_test  = 1'b1;
      end
      FPL_PASSED:   next_test = 1'b1;
      FPL_MGR_INIT: begin
        next_test = 1'b1;
        next_onl  = 1'b1;
      end
      FPL_ONLINE:   next_onl = 1'b1;
      FPL_FAIL_MGR: begin
        next_drive = 1'b1;
        next_test  = 1'b1;
        next_onl   = 1'b1;
      end
      FPL_FAIL_ONL: begin
        next_drive = 1'b1;
        next_onl   = 1'b1;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Failure line drive
  //////////////////////////////////////////////////////////////////////////////

  // Open drain: only ever pull low, enable says when
  // Never drives high, so two boards pulling at once cannot fight
  assign sysfail_n_out = 1'b0;

  // Same decode feeds the enable flop and the failed lamp flop, so they cannot part
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysfail_n_oe <= 1'b0;
    end else begin
      sysfail_n_oe <= next_drive;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Activity stretchers
  //////////////////////////////////////////////////////////////////////////////

  logic [1:0] act_trig;  // Access, drive
  logic [1:0] act_lamp;  // Stretched lamp levels

  assign act_trig[0] = pin_sync[PIN_MODID] || pin_sync[PIN_REMOTE];
  assign act_trig[1] = pin_sync[PIN_DISK];

  // One stretcher per activity lamp
  // Trade-off: a held trigger keeps the lamp lit, so a busy disk looks steady
  generate
    for (gi = 0; gi < 2; gi++) begin : g_str
      fpl_stretch #(
        .MIN_TICKS (MIN_TICKS)
      ) u_str (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick),
        .trig    (act_trig[gi]),
        .lamp    (act_lamp[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Lamp register
  //////////////////////////////////////////////////////////////////////////////

  // All seven lamps from flops; dark in reset
  // One extra cycle of latency keeps every lamp free of glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamps <= '0;
    end else begin
      lamps.failed          <= next_drive;
      lamps.test            <= next_test;
      lamps.online          <= next_onl;
      lamps.sysfail         <= pin_sync[PIN_SYSFAIL];
      lamps.access          <= act_lamp[0];
      lamps.drive           <= act_lamp[1];
      lamps.full_speed_lamp <= pin_sync[PIN_SPEED];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Events, status, mask, interrupt
  //////////////////////////////////////////////////////////////////////////////

  logic [EV_N-1:0] ev_set;  // Events this cycle
  logic [EV_N-1:0] status;  // Sticky event bits
  logic [EV_N-1:0] mask;    // Interrupt enables
  logic [EV_N-1:0] clr;     // Write-one-to-clear bits

  // Edges come from the synced copies, never from the raw pins
  assign ev_set[EV_SYSFAIL] = pin_sync[PIN_SYSFAIL] && !pin_prev[PIN_SYSFAIL];
  assign ev_set[EV_ACCESS]  = pin_sync[PIN_REMOTE] && !pin_prev[PIN_REMOTE];
  assign ev_set[EV_BADSTEP] = wr_stage && !step_ok;
  assign ev_set[EV_STAGE]   = wr_stage && step_ok;
  assign clr                = wr_status ? pwdata[EV_N-1:0] : '0;

  // Set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= STATUS_RST;
    end else begin
      status <= (status & ~clr) | ev_set;
    end
  end

  // Mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= MASK_RST;
    end else if (wr_mask) begin
      mask <= pwdata[EV_N-1:0];
    end
  end

  // Level interrupt from a flop
  // Registered, so it lags the status bit by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data
  //////////////////////////////////////////////////////////////////////////////

  logic [31:0] next_rdata;  // Read mux

  // Unused bits and unmapped addresses read zero
  // Reading status does not clear it; software writes ones to clear
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (paddr)
      OFF_STAGE:  next_rdata[2:0]      = stage;
      OFF_STATUS: next_rdata[EV_N-1:0] = status;
      OFF_MASK:   next_rdata[EV_N-1:0] = mask;
      OFF_LAMPS:  next_rdata[6:0]      = lamps;
      default:    next_rdata           = 32'h0000_0000;
    endcase
  end

  // Captured in the setup cycle, so it stands through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata <= next_rdata;
    end
  end

endmodule

// ===== verif/fpl_backplane.sv
`timescale 1ns/1ps
// Backplane failure line: open drain with a pull-up, so released reads high
module fpl_backplane (
  input  wire logic sysfail_n_out,
  input  wire logic sysfail_n_oe,
  input  wire logic other_fail,
  output logic      sysfail_n_wire
);
  // Low while this board or another module pulls it
  always_comb sysfail_n_wire = !((sysfail_n_oe && !sysfail_n_out) || other_fail);
endmodule

// ===== verif/fpl_checker.sv
`timescale 1ns/1ps
module fpl_checker
  import fpl_pkg::*;
#(
  parameter int unsigned TICK_DIV  = 4,
  parameter int unsigned MIN_TICKS = 3
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       sysfail_n_in,
  input wire logic       sysfail_n_oe,
  input wire logic       modid_in,
  input wire logic       remote_access,
  input wire logic       disk_busy,
  input wire logic       cpu_full_speed,
  input wire fpl_lamps_t lamps
);
  logic [31:0] acc_idle;  // Cycles since access trigger low
  logic [31:0] drv_idle;  // Cycles since disk idle
  logic [2:0]  code;      // Failed, test, online
  assign code = {lamps.failed, lamps.test, lamps.online};

  // Legal lamp code steps; anything else means a skipped stage
  function automatic bit ok_step(logic [2:0] a, logic [2:0] b);
    return {a, b} inside {6'h04, 6'h26, 6'h32, 6'h13, 6'h19, 6'h1F, 6'h0D};
  endfunction

  // Idle counters, each cleared by its own trigger
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_idle <= '0;
      drv_idle <= '0;
    end else begin
      acc_idle <= (modid_in || remote_access) ? '0 : acc_idle + 1;
      drv_idle <= disk_busy ? '0 : drv_idle + 1;
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Pins settle through two sync flops plus the lamp register
  sequence s_wire_low; (!sysfail_n_in)[*4]; endsequence
  sequence s_wire_high; sysfail_n_in[*4]; endsequence
  sequence s_acc_held; (modid_in || remote_access)[*5]; endsequence

  property p_local_fail; lamps.failed == sysfail_n_oe; endproperty
  property p_sf_on; s_wire_low |-> lamps.sysfail; endproperty
  property p_sf_off; s_wire_high |-> !lamps.sysfail; endproperty
  property p_step; $changed(code) |-> ok_step($past(code), code); endproperty
  property p_final; code inside {3'b111, 3'b101} |=> $stable(code); endproperty
  property p_acc_on; s_acc_held |-> lamps.access; endproperty
  property p_acc_min; $fell(lamps.access) |-> acc_idle >= (MIN_TICKS-1)*TICK_DIV; endproperty
  property p_acc_off; acc_idle > MIN_TICKS*TICK_DIV+8 |-> !lamps.access; endproperty
  property p_drv_on; disk_busy[*5] |-> lamps.drive; endproperty
  property p_drv_off; drv_idle > MIN_TICKS*TICK_DIV+8 |-> !lamps.drive; endproperty
  property p_spd; $stable(cpu_full_speed)[*4] |-> lamps.full_speed_lamp == cpu_full_speed;
  endproperty

  a_local_fail: assert property (p_local_fail) else $error("failed lamp differs");
  a_sf_on: assert property (p_sf_on) else $error("sysfail lamp dark");
  a_sf_off: assert property (p_sf_off) else $error("sysfail lamp lit");
  a_step: assert property (p_step) else $error("illegal lamp step");
  a_final: assert property (p_final) else $error("failure code left");
  a_acc_on: assert property (p_acc_on) else $error("access lamp dark");
  a_acc_min: assert property (p_acc_min) else $error("access flash short");
  a_acc_off: assert property (p_acc_off) else $error("access lamp stuck");
  a_drv_on: assert property (p_drv_on) else $error("drive lamp dark");
  a_drv_off: assert property (p_drv_off) else $error("drive lamp stuck");
  a_spd: assert property (p_spd) else $error("speed lamp wrong");
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import fpl_pkg::*;
;
  localparam int unsigned TDIV = 4;  // Short tick keeps the run brief
  localparam int unsigned MTK  = 3;  // Short hold, in ticks
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rdata, d;
  logic              rerr, b, sysfail_n_in, sysfail_n_out, sysfail_n_oe, other_fail;
  logic              cpu_full_speed;
  logic [2:0]        trig;  // Disk, remote, module id
  wire               modid_in, remote_access, disk_busy;
  fpl_lamps_t        lamps;
  int                err_count, check_count, m_stage, m_stat, m_mask;
  int                seed = 32'he088_6446;
  int                tab[8] = '{0, 1, 3, 2, 6, 4, 7, 5};  // Lamp code {online,test,failed}
  assign {disk_busy, remote_access, modid_in} = trig;

  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  fpl_top #(.TICK_DIV(TDIV), .MIN_TICKS(MTK)) u_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sysfail_n_in, .sysfail_n_out,
    .sysfail_n_oe, .modid_in, .remote_access, .disk_busy, .cpu_full_speed, .lamps, .irq);
  fpl_backplane u_bp (.sysfail_n_out, .sysfail_n_oe, .other_fail,
    .sysfail_n_wire(sysfail_n_in));

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One APB transfer; holds the request until pready is seen
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_count++;
      conclude();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Stage write against the model; random upper bits must be ignored
  task automatic wstage(input int t);
    bit ok;
    int old;
    ok = (t == m_stage + 1 && m_stage < 5) || (m_stage == 4 && t == 6) ||
         (m_stage == 5 && t == 7);
    old = tab[m_stage];
    apb(OFF_STAGE, 1'b1, ($random(seed) & 32'hFFFF_FFF8) | 32'(t));
    if (ok) m_stage = t;
    m_stat |= ok ? 8 : 4;
    if (!old[0] && tab[m_stage][0] && !other_fail) m_stat |= 1;
    repeat (6) @(posedge pclk);
    chk("lamp_code", tab[m_stage], {29'b0, lamps[2:0]});
    chk("own_drive", tab[m_stage] & 1, sysfail_n_oe);
    chk("pull_level", 0, sysfail_n_out);
    chk("sysfail_lamp", (tab[m_stage] & 1) | other_fail, lamps.sysfail);
    apb(OFF_STAGE, 1'b0, '0);
    chk("stage", m_stage, rdata);
    apb(OFF_STATUS, 1'b0, '0);
    chk("status", m_stat, rdata);
    chk("irq", (m_stat & m_mask) != 0, irq);
    apb(OFF_STATUS, 1'b1, 32'h0000_000F);
    m_stat = 0;
  endtask

  // Trigger held len cycles must light if len exceeds 4, flash past its fall, then go dark
  task automatic pulse(input int i, input int len);
    @(posedge pclk);
    trig <= 3'(1 << i);
    repeat (len) @(posedge pclk);
    if (len > 4) chk("held", 1, i == 2 ? lamps.drive : lamps.access);
    trig <= 3'b000;
    if (i == 1) m_stat |= 2;
    repeat (9) @(posedge pclk);
    chk("flash", 1, i == 2 ? lamps.drive : lamps.access);
    repeat (20) @(posedge pclk);
    chk("dark", 0, i == 2 ? lamps.drive : lamps.access);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, other_fail, cpu_full_speed} = '0;
    paddr = '0;
    pwdata = '0;
    trig = '0;
    {err_count, check_count, m_stage, m_stat, m_mask} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk("lamp_count", 7, $bits(fpl_lamps_t));
    for (int a = 0; a < 20; a += 4) begin
      apb(8'(a), 1'b0, '0);
      chk("reset_reg", 0, rdata);
      chk("slverr", a == 16, rerr);
    end
    d = $random(seed) | 32'h5;
    apb(OFF_MASK, 1'b1, d);
    m_mask = d[3:0];
    apb(OFF_MASK, 1'b0, '0);
    chk("mask", m_mask, rdata);
    wstage(1);
    wstage(3);
    wstage(2);
    wstage(3);
    // Another module pulls the line: global lamp only
    other_fail <= 1'b1;
    m_stat |= 1;
    repeat (6) @(posedge pclk);
    chk("other_fail", 1, lamps.sysfail);
    chk("not_local", 0, lamps.failed);
    apb(OFF_MASK, 1'b1, '0);
    repeat (2) @(posedge pclk);
    chk("irq_masked", 0, irq);
    apb(OFF_MASK, 1'b1, 32'(m_mask));
    repeat (2) @(posedge pclk);
    chk("irq_raised", 1, irq);
    other_fail <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("line_free", 0, lamps.sysfail);
    for (int i = 0; i < 3; i++) begin
      pulse(i, 2);
      pulse(i, 8);
    end
    apb(OFF_STATUS, 1'b0, '0);
    chk("status_ev", m_stat, rdata);
    apb(OFF_STATUS, 1'b1, 32'(m_stat));
    m_stat = 0;
    repeat (2) @(posedge pclk);
    chk("irq_clear", 0, irq);
    repeat (6) begin
      b = 1'($random(seed));
      cpu_full_speed <= b;
      repeat (5) @(posedge pclk);
      chk("speed", b, lamps.full_speed_lamp);
    end
    for (int t = 4; t < 8; t++) wstage(t);
    wstage(5);
    apb(OFF_LAMPS, 1'b1, '0);
    apb(OFF_LAMPS, 1'b0, '0);
    chk("lamps_reg", 32'(tab[7]) | 32'h8 | {25'b0, b, 6'b0}, rdata);
    // Second reset mid-run, then fail during resource_manager startup
    presetn <= 1'b0;
    cpu_full_speed <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    {m_stage, m_stat} = '0;
    chk("reset_lamps", 0, lamps);
    chk("reset_oe", 0, sysfail_n_oe);
    chk("reset_irq", 0, irq);
    apb(OFF_MASK, 1'b1, 32'h0000_000F);
    m_mask = 15;
    for (int t = 1; t < 5; t++) wstage(t);
    wstage(6);
    wstage(0);
    conclude();
  end
endmodule

bind fpl_top fpl_checker #(.TICK_DIV(TICK_DIV), .MIN_TICKS(MIN_TICKS)) u_chk (.pclk,
  .presetn, .sysfail_n_in, .sysfail_n_oe, .modid_in, .remote_access, .disk_busy,
  .cpu_full_speed, .lamps);
